// ---- verilog/nvp_top.sv ----
// network variable publisher: timers, publication, commands, apb registers
// Functional notes
// [R1] leave user mode after ten idle hours; the count runs from entry and nothing in user mode restarts it
// [R2] key held 3 s exits; reentry reissues id
// [R3] concentration published equals display value
// [R4] status word holds unit, alarms, fault
// [R5] alarm switch 0.0/1.0/1.5/2.0 encoding
// [R6] fault switch 1.0/5.0/7.0/9.0 encoding
// [R7] label: name, space, unit, nulls
// [R8] heartbeat low byte counts seconds, wraps
// [R9] nonzero latch write clears latched alarms
// [R10] max interval resends; zero disables
// [R11] min interval delays updated sends
// [R12] zero min interval sends changes at once
// [R13] indication group has own interval pair
// [R14] heartbeat sent at its interval; zero stops
// [R15] 30-byte command in, 30-byte reply out
// [R16] A1 read returns first setpoint hex
// [R17] A2 read returns second setpoint hex
// [R18] AD read returns delay hex
// [R19] one-second tick paces all timers; the key hold counts pclk cycles instead
`timescale 1ns/1ns
module nvp_top #(
   parameter longint TICK_CYCLES = nvp_pkg::TICK_CYC,
   parameter longint KEY_CYCLES  = nvp_pkg::KEY_HOLD_CYC
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic              pready,
   output logic [31:0]       prdata,
   output logic              pslverr,
   output logic              irq,
   input  wire logic         mode_key_n,
   input  wire logic [15:0]  display_conc,
   input  wire logic [3:0]   unit_code,
   input  wire logic         alarm1_on,
   input  wire logic         alarm2_on,
   input  wire logic         fault_sensor,
   input  wire logic         fault_flow,
   input  wire logic         fault_pyro,
   input  wire logic         fault_system,
   input  wire logic [63:0]  gas_name,
   input  wire logic [31:0]  unit_text,
   input  wire logic [15:0]  latch_clear_in,
   input  wire logic         latch_clear_valid,
   input  wire logic [239:0] command_in,
   input  wire logic         command_valid,
   output logic [15:0]       concentration_out,
   output logic [15:0]       node_status_out,
   output logic [15:0]       alarm_switch_out,
   output logic [15:0]       fault_switch_out,
   output logic [127:0]      gas_label_out,
   output logic [15:0]       heartbeat_out,
   output logic              meas_send,
   output logic              ind_send,
   output logic              hb_send,
   output logic [239:0]      command_reply_out,
   output logic              reply_send,
   output logic              latch_clear_pulse,
   output logic              node_id_reissue,
   output logic              user_mode
);
   import nvp_pkg::*;
   initial begin
      if (TICK_CYCLES < 2 || KEY_CYCLES < 1 || TICK_CYCLES >= 64'h1_0000_0000 ||
          KEY_CYCLES >= 64'h1_0000_0000) begin
         $error("nvp_top: tick or key count out of range");
      end
   end

   // ************
   // helper functions
   // ************
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction : hex_char

   // name bytes up to the first null, a space, then the unit, zero fill
   function automatic logic [127:0] build_label(input logic [63:0] nm,
                                                input logic [31:0] un);
      logic [127:0] r;
      int           n;
      r = '0;
      n = 0;
      for (int i = 0; i < 8; i++) begin
         if (nm[8*i+:8] != 8'h00 && n == i) begin
            r[8*i+:8] = nm[8*i+:8];
            n = i + 1;
         end
      end
      r[8*n+:8] = ASC_SPACE;
      for (int j = 0; j < 4; j++) begin
         r[8*(n+1+j)+:8] = un[8*j+:8];
      end
      build_label = r;
   endfunction : build_label

   // ************
   // one-second tick
   // ************
   logic [31:0] tick_cnt;
   logic        tick;
   wire         tick_end = (tick_cnt == 32'(TICK_CYCLES - 1));

   // every second-based timer advances on this single strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b0;
      end else begin
         tick_cnt <= tick_end ? 32'h0000_0000 : tick_cnt + 32'h0000_0001; // [R19]
         tick     <= tick_end; // [R19]
      end
   end

   // ************
   // apb decode and config storage
   // ************
   logic [15:0]       cfg [1:CFG_LAST];
   logic [IRQ_W-1:0]  irq_stat;
   logic [IRQ_W-1:0]  irq_mask;
   logic [IRQ_W-1:0]  irq_evt;
   wire  [3:0]        reg_idx  = paddr[5:2];
   wire               setup    = psel & ~penable;
   wire               access   = psel & penable;
   wire               hit      = (paddr[1:0] == 2'b00) && (paddr <= ADDR_MODE_STAT);
   wire               cfg_hit  = (reg_idx >= 4'(CFG_MEAS_MAX)) && (reg_idx <= 4'(CFG_LAST));
   wire               wr_cfg   = access & pwrite & hit & cfg_hit;
   wire               wr_ctrl  = access & pwrite & (paddr == ADDR_CTRL) & pwdata[0];
   wire               wr_mask  = access & pwrite & (paddr == ADDR_IRQ_MASK);
   wire               rd_stat  = access & ~pwrite & (paddr == ADDR_IRQ_STAT);
   logic [31:0]       rd_mux;

   // read data is looked up during setup so prdata can come from a flop
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit && cfg_hit) begin
         rd_mux = {16'h0000, cfg[reg_idx]};
      end else if (paddr == ADDR_IRQ_STAT) begin
         rd_mux = {26'h0, irq_stat};
      end else if (paddr == ADDR_IRQ_MASK) begin
         rd_mux = {26'h0, irq_mask};
      end else if (paddr == ADDR_MODE_STAT) begin
         rd_mux = {16'h0000, heartbeat_out[7:0], 7'h00, user_mode};
      end
   end

   // zero-wait slave: every access completes in its first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~hit;
         end
      end
   end

   // config words; unmapped writes are dropped and flagged by pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 1; i <= CFG_LAST; i++) begin
            cfg[i] <= CFG_RESET;
         end
      end else if (wr_cfg) begin
         cfg[reg_idx] <= pwdata[15:0];
      end
   end

   // sticky events; a new event wins over the read that clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq      <= 1'b0;
      end else begin
         irq_stat <= (rd_stat ? '0 : irq_stat) | irq_evt;
         if (wr_mask) begin
            irq_mask <= pwdata[IRQ_W-1:0];
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   // ************
   // mode key and user mode
   // ************
   logic        key_s1;
   logic        key_s2;
   logic [31:0] key_cnt;
   logic [15:0] user_secs;
   logic        reissue_armed;
   nvp_mode_type mode;
   wire         key_exit   = (mode == NVP_USER) && !key_s2 && (key_cnt == 32'(KEY_CYCLES - 1));
   wire         time_exit  = (mode == NVP_USER) && (user_secs >= USER_TIMEOUT_TICKS);
   wire         enter_user = (mode == NVP_DETECT) && wr_ctrl;

   // the key is a pin, so it is synchronised before the hold counter sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_s1 <= 1'b1;
         key_s2 <= 1'b1;
         key_cnt <= 32'h0000_0000;
      end else begin
         key_s1 <= mode_key_n;
         key_s2 <= key_s1;
         key_cnt <= (key_s2 || mode == NVP_DETECT) ? 32'h0000_0000 : key_cnt + 32'h0000_0001; // [R2]
      end
   end

   // mode machine; only a key-hold exit arms the identifier reissue
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode            <= NVP_DETECT;
         user_secs       <= 16'h0000;
         reissue_armed   <= 1'b0;
         node_id_reissue <= 1'b0;
         user_mode       <= 1'b0;
      end else begin
         node_id_reissue <= 1'b0;
         unique case (mode)
            NVP_DETECT: begin
               user_secs <= 16'h0000;
               if (enter_user) begin
                  mode            <= NVP_USER;
                  node_id_reissue <= reissue_armed; // [R2]
                  reissue_armed   <= 1'b0;
               end
            end
            NVP_USER: begin
               if (tick) begin
                  user_secs <= user_secs + 16'h0001; // [R1]
               end
               if (key_exit) begin
                  mode          <= NVP_DETECT; // [R2]
                  reissue_armed <= 1'b1; // [R2]
               end else if (time_exit) begin
                  mode <= NVP_DETECT; // [R1]
               end
            end
         endcase
         user_mode <= (mode == NVP_USER);
      end
   end

   // ************
   // variable values
   // ************
   // switch values; a system fault outranks the narrower fault causes
   wire  [7:0]  alm_val = alarm2_on ? (alarm1_on ? SW_2_0 : SW_1_5)
                                    : (alarm1_on ? SW_1_0 : SW_OFF); // [R5]
   wire  [7:0]  flt_val = fault_system ? SW_9_0 : fault_pyro ? SW_7_0 :
                          fault_flow ? SW_5_0 : fault_sensor ? SW_1_0 : SW_OFF; // [R6]
   wire         any_fault = fault_sensor | fault_flow | fault_pyro | fault_system;
   wire  [15:0] status_now = {8'h00, any_fault, alarm2_on, alarm1_on, 1'b0, unit_code}; // [R4]
   wire  [15:0] alm_now    = {alm_val, (alarm1_on | alarm2_on) ? SW_ON : SW_OFF}; // [R5]
   wire  [15:0] flt_now    = {flt_val, any_fault ? SW_ON : SW_OFF}; // [R6]
   wire  [127:0] label_now = build_label(gas_name, unit_text); // [R7]

   // ************
   // send scheduling per variable group
   // ************
   wire  [GRP_W-1:0] grp_now [2];
   wire  [15:0]      grp_max [2];
   wire  [15:0]      grp_min [2];
   logic [GRP_W-1:0] grp_last [2];
   logic [15:0]      grp_age [2];
   logic [1:0]       grp_fire;
   assign grp_now[0] = {128'h0, display_conc, status_now}; // [R3]
   assign grp_now[1] = {alm_now, flt_now, label_now};
   assign grp_max[0] = cfg[CFG_MEAS_MAX];
   assign grp_min[0] = cfg[CFG_MEAS_MIN];
   assign grp_max[1] = cfg[CFG_IND_MAX]; // [R13]
   assign grp_min[1] = cfg[CFG_IND_MIN]; // [R13]
   // both groups share one scheduler shape with their own interval pair
   for (genvar g = 0; g < 2; g++) begin : g_grp
      wire changed  = (grp_now[g] != grp_last[g]);
      wire min_ok   = (grp_min[g] == 16'h0000) || (grp_age[g] >= grp_min[g]); // [R11] [R12]
      wire max_due  = (grp_max[g] != 16'h0000) && (grp_age[g] >= grp_max[g]); // [R10]
      assign grp_fire[g] = (changed && min_ok) || max_due;
      // age saturates so a long quiet spell cannot wrap into a false wait
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            grp_last[g] <= '0;
            grp_age[g]  <= 16'h0000;
         end else if (grp_fire[g]) begin
            grp_last[g] <= grp_now[g];
            grp_age[g]  <= 16'h0000;
         end else if (tick && grp_age[g] != 16'hFFFF) begin
            grp_age[g] <= grp_age[g] + 16'h0001; // [R19]
         end
      end
   end

   // published copies follow the value that was actually sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         concentration_out <= 16'h0000;
         node_status_out   <= 16'h0000;
         alarm_switch_out  <= 16'h0000;
         fault_switch_out  <= 16'h0000;
         gas_label_out     <= 128'h0;
         meas_send         <= 1'b0;
         ind_send          <= 1'b0;
      end else begin
         meas_send <= grp_fire[0]; // [R10] [R11] [R12]
         ind_send  <= grp_fire[1]; // [R13]
         if (grp_fire[0]) begin
            concentration_out <= display_conc; // [R3]
            node_status_out   <= status_now; // [R4]
         end
         if (grp_fire[1]) begin
            alarm_switch_out <= alm_now;
            fault_switch_out <= flt_now;
            gas_label_out    <= label_now; // [R7]
         end
      end
   end

   // ************
   // heartbeat
   // ************
   logic [15:0] hb_age;
   wire         hb_due = (cfg[CFG_HB_INT] != 16'h0000) && (hb_age >= cfg[CFG_HB_INT]); // [R14]

   // count runs whether or not it is transmitted; upper byte stays zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         heartbeat_out <= 16'h0000;
         hb_age        <= 16'h0000;
         hb_send       <= 1'b0;
      end else begin
         hb_send <= hb_due; // [R14]
         if (tick) begin
            heartbeat_out[7:0] <= heartbeat_out[7:0] + 8'h01; // [R8]
         end
         if (hb_due) begin
            hb_age <= 16'h0000;
         end else if (tick && hb_age != 16'hFFFF) begin
            hb_age <= hb_age + 16'h0001; // [R19]
         end
      end
   end

   // ************
   // latch clear and command replies
   // ************
   logic [239:0] reply_now;
   logic         reply_ok;
   wire  [47:0]  cmd_head = command_in[47:0];
   wire  [15:0]  sp_sel = (cmd_head == CMD_A1) ? cfg[CFG_ALM1] : cfg[CFG_ALM2]; // [R16] [R17]
   wire  [15:0]  dly = cfg[CFG_DLY];

   // echo the six command bytes, then the value as upper-case hex
   always_comb begin
      reply_now = '0;
      reply_ok  = 1'b1;
      reply_now[47:0] = cmd_head; // [R15]
      if (cmd_head == CMD_A1 || cmd_head == CMD_A2) begin
         reply_now[55:48] = ASC_SPACE;
         for (int k = 0; k < 4; k++) begin
            reply_now[56+8*k+:8] = hex_char(sp_sel[12-4*k+:4]); // [R16] [R17]
         end
      end else if (cmd_head == CMD_AD) begin
         for (int k = 0; k < 3; k++) begin
            reply_now[48+8*k+:8] = hex_char(dly[8-4*k+:4]); // [R18]
         end
      end else begin
         reply_ok = 1'b0;
      end
   end

   // unknown commands get no reply; zero latch writes are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         command_reply_out <= 240'h0;
         reply_send        <= 1'b0;
         latch_clear_pulse <= 1'b0;
      end else begin
         reply_send        <= command_valid & reply_ok; // [R15]
         latch_clear_pulse <= latch_clear_valid & (latch_clear_in != 16'h0000); // [R9]
         if (command_valid && reply_ok) begin
            command_reply_out <= reply_now; // [R15]
         end
      end
   end
   assign irq_evt = {time_exit, latch_clear_valid & (latch_clear_in != 16'h0000),
                     command_valid & reply_ok, hb_due, grp_fire[1], grp_fire[0]};
endmodule : nvp_top

// ---- verilog/nvp_pkg.sv ----
// constants of the network variable publisher
package nvp_pkg;
   // ************
   // register map (byte addresses)
   // ************
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_MEAS_MAX  = 8'h04;
   localparam logic [7:0] ADDR_MEAS_MIN  = 8'h08;
   localparam logic [7:0] ADDR_IND_MAX   = 8'h0C;
   localparam logic [7:0] ADDR_IND_MIN   = 8'h10;
   localparam logic [7:0] ADDR_HB_INT    = 8'h14;
   localparam logic [7:0] ADDR_ALM1_SET  = 8'h18;
   localparam logic [7:0] ADDR_ALM2_SET  = 8'h1C;
   localparam logic [7:0] ADDR_ALM_DELAY = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h28;
   localparam logic [7:0] ADDR_MODE_STAT = 8'h2C;
   // config word indices inside the storage array
   localparam int CFG_MEAS_MAX = 1;
   localparam int CFG_MEAS_MIN = 2;
   localparam int CFG_IND_MAX  = 3;
   localparam int CFG_IND_MIN  = 4;
   localparam int CFG_HB_INT   = 5;
   localparam int CFG_ALM1     = 6;
   localparam int CFG_ALM2     = 7;
   localparam int CFG_DLY      = 8;
   localparam int CFG_LAST     = 8;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // ************
   // interrupt status bit positions
   // ************
   localparam int IRQ_MEAS    = 0;
   localparam int IRQ_IND     = 1;
   localparam int IRQ_HB      = 2;
   localparam int IRQ_REPLY   = 3;
   localparam int IRQ_LATCH   = 4;
   localparam int IRQ_TIMEOUT = 5;
   localparam int IRQ_W       = 6;
   // ************
   // timing
   // ************
   localparam longint CLK_HZ        = 100_000_000;
   localparam int     TICK_S        = 1;
   localparam int     KEY_HOLD_S    = 3;
   localparam int     USER_TIMEOUT_H = 10;
   localparam logic [15:0] USER_TIMEOUT_TICKS = 16'(USER_TIMEOUT_H * 3600 / TICK_S);
   localparam longint TICK_CYC      = CLK_HZ * TICK_S;
   localparam longint KEY_HOLD_CYC  = CLK_HZ * KEY_HOLD_S;
   // ************
   // switch values in tenths, ascii and commands
   // ************
   localparam logic [7:0] SW_OFF  = 8'h00;
   localparam logic [7:0] SW_1_0  = 8'h0A;
   localparam logic [7:0] SW_1_5  = 8'h0F;
   localparam logic [7:0] SW_2_0  = 8'h14;
   localparam logic [7:0] SW_5_0  = 8'h32;
   localparam logic [7:0] SW_7_0  = 8'h46;
   localparam logic [7:0] SW_9_0  = 8'h5A;
   localparam logic [7:0] SW_ON   = 8'h01;
   localparam logic [7:0] ASC_SPACE = 8'h20;
   localparam int CMD_BYTES = 30;
   localparam int LABEL_BYTES = 16;
   localparam int GRP_W = 160;
   // first byte of the command sits in the low bits
   localparam logic [47:0] CMD_A1 = {8'h2C, 8'h52, 8'h20, 8'h2C, 8'h31, 8'h41};
   localparam logic [47:0] CMD_A2 = {8'h2C, 8'h52, 8'h20, 8'h2C, 8'h32, 8'h41};
   localparam logic [47:0] CMD_AD = {8'h2C, 8'h52, 8'h20, 8'h2C, 8'h44, 8'h41};
   typedef enum logic {NVP_DETECT = 1'b0, NVP_USER = 1'b1} nvp_mode_type;
endpackage : nvp_pkg

// ---- tb/nvp_assertions.sv ----
// port checks for the network variable publisher
`timescale 1ns/1ns
module nvp_assertions
   import nvp_pkg::*;
(
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pready,
   input wire logic [15:0]  display_conc,
   input wire logic         meas_send,
   input wire logic [15:0]  concentration_out,
   input wire logic [15:0]  node_status_out,
   input wire logic         ind_send,
   input wire logic [15:0]  alarm_switch_out,
   input wire logic [15:0]  fault_switch_out,
   input wire logic [15:0]  heartbeat_out,
   input wire logic [15:0]  latch_clear_in,
   input wire logic         latch_clear_valid,
   input wire logic         latch_clear_pulse,
   input wire logic [239:0] command_in,
   input wire logic         command_valid,
   input wire logic [239:0] command_reply_out,
   input wire logic         reply_send,
   input wire logic         node_id_reissue
);
   // ************
   // properties
   // ************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   conc_copy_a: assert property (meas_send |-> concentration_out == $past(display_conc))
      else $error("concentration differs from display");
   status_rsvd_a: assert property (meas_send |-> node_status_out[15:8] == 8'h00)
      else $error("status upper byte set");
   alarm_state_a: assert property (ind_send |->
      alarm_switch_out[7:0] == ((alarm_switch_out[15:8] != 8'h00) ? SW_ON : SW_OFF))
      else $error("alarm state and value disagree");
   fault_state_a: assert property (ind_send |->
      fault_switch_out[7:0] == ((fault_switch_out[15:8] != 8'h00) ? SW_ON : SW_OFF))
      else $error("fault state and value disagree");
   hb_upper_a: assert property (heartbeat_out[15:8] == 8'h00)
      else $error("heartbeat upper byte set");
   clr_zero_a: assert property (latch_clear_valid && latch_clear_in == 16'h0000
      |=> !latch_clear_pulse)
      else $error("zero write cleared latch");
   clr_nonzero_a: assert property (latch_clear_valid && latch_clear_in != 16'h0000
      |=> latch_clear_pulse)
      else $error("nonzero write ignored");
   reply_first_a: assert property (command_valid && command_in[47:0] == CMD_A1
      |=> reply_send && command_reply_out[47:0] == CMD_A1)
      else $error("first setpoint reply missing");
   reply_delay_a: assert property (command_valid && command_in[47:0] == CMD_AD
      |=> reply_send && command_reply_out[47:0] == CMD_AD)
      else $error("delay reply missing");
   cover property (meas_send);
   cover property (reply_send);
   cover property (node_id_reissue);
endmodule : nvp_assertions

// ---- tb/nvp_net_model.sv ----
// model of the control network writing to the node
`timescale 1ns/1ns
module nvp_net_model (
   input wire logic  pclk,
   output logic [15:0]  latch_clear_in,
   output logic         latch_clear_valid,
   output logic [239:0] command_in,
   output logic         command_valid
);
   initial begin
      latch_clear_in = 16'h0000;
      latch_clear_valid = 1'b0;
      command_in = 240'h0;
      command_valid = 1'b0;
   end
   // one-cycle write; the value is inverted after, never held
   task clr(input logic [15:0] v);
      @(posedge pclk);
      latch_clear_in <= v;
      latch_clear_valid <= 1'b1;
      @(posedge pclk);
      latch_clear_valid <= 1'b0;
      latch_clear_in <= ~v;
   endtask : clr
   // whole 30-byte command string in one update
   task cmd(input logic [239:0] c);
      @(posedge pclk);
      command_in <= c;
      command_valid <= 1'b1;
      @(posedge pclk);
      command_valid <= 1'b0;
      command_in <= ~c;
   endtask : cmd
endmodule : nvp_net_model

// ---- tb/test_network_variable_publisher.sv ----
// self-checking bench for the network variable publisher
`timescale 1ns/1ns
module test_network_variable_publisher;
   import nvp_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic mode_key_n = 1, alarm1_on = 0, alarm2_on = 0;
   logic fault_sensor = 0, fault_flow = 0, fault_pyro = 0, fault_system = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [15:0] display_conc = 16'h0000, hv, latch_clear_in;
   logic [3:0] unit_code = 4'h3;
   logic [63:0] gas_name = 64'h3248;
   logic [31:0] unit_text = 32'h6D7070;
   logic [239:0] command_in, command_reply_out;
   logic latch_clear_valid, command_valid, pready, pslverr, irq, meas_send, ind_send;
   logic hb_send, reply_send, latch_clear_pulse, node_id_reissue, user_mode;
   logic [15:0] concentration_out, node_status_out, alarm_switch_out;
   logic [15:0] fault_switch_out, heartbeat_out;
   logic [127:0] gas_label_out;
   logic [7:0] av [4] = '{SW_OFF, SW_1_0, SW_1_5, SW_2_0};
   logic [7:0] fv [4] = '{SW_1_0, SW_5_0, SW_7_0, SW_9_0};
   int fails = 0, n_checks = 0, nw, nm = 0, nh = 0, nl = 0, nid = 0, c;
   nvp_top #(.TICK_CYCLES(20), .KEY_CYCLES(10)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq, .mode_key_n,
      .display_conc, .unit_code, .alarm1_on, .alarm2_on, .fault_sensor, .fault_flow,
      .fault_pyro, .fault_system, .gas_name, .unit_text, .latch_clear_in,
      .latch_clear_valid, .command_in, .command_valid, .concentration_out,
      .node_status_out, .alarm_switch_out, .fault_switch_out, .gas_label_out,
      .heartbeat_out, .meas_send, .ind_send, .hb_send, .command_reply_out, .reply_send,
      .latch_clear_pulse, .node_id_reissue, .user_mode);
   nvp_net_model net (.pclk, .latch_clear_in, .latch_clear_valid, .command_in,
      .command_valid);
   always #5 pclk = ~pclk;
   // pulse counters
   always @(posedge pclk) begin
      nm += (meas_send === 1'b1);
      nh += (hb_send === 1'b1);
      nl += (latch_clear_pulse === 1'b1);
      nid += (node_id_reissue === 1'b1);
   end
   task wrap_up;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   task ck(input logic [239:0] g, input logic [239:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %0h exp %0h", $time, g, e);
      end
   endtask : ck
   // apb master: held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic sg(input int k);
      return k == 0 ? meas_send : k == 1 ? ind_send : k == 2 ? hb_send : reply_send;
   endfunction : sg
   // bounded wait for a send pulse, nw keeps the cycle count
   task wt(input int k);
      nw = 0;
      #1;
      while (sg(k) !== 1'b1 && nw < 300) begin
         @(posedge pclk);
         #1;
         nw++;
      end
      ck(nw < 300, 1);
   endtask : wt
   task cq(input logic [47:0] cm, input logic [15:0] v, input int nd, input int st);
      logic [239:0] e;
      e = 240'(cm);
      if (st == 7) e[55:48] = ASC_SPACE;
      for (int i = 0; i < nd; i++) e[8*(st+i) +: 8] = 8'h30 + 8'(v[4*(nd-1-i) +: 4]);
      net.cmd(240'(cm));
      wt(3);
      ck(command_reply_out, e);
   endtask : cq
   // watchdog: the sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      wrap_up();
   end
   // ************
   // main sequence
   // ************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1, ADDR_ALM1_SET, 32'h1234);
      apb(1, ADDR_ALM2_SET, 32'h0987);
      apb(1, ADDR_ALM_DELAY, 32'h0250);
      apb(0, ADDR_ALM1_SET, 0);
      ck(rd, 32'h1234);
      apb(0, 8'h30, 0);
      ck({err, rd}, 33'h100000000);
      cq(CMD_A1, 16'h1234, 4, 7);
      cq(CMD_A2, 16'h0987, 4, 7);
      cq(CMD_AD, 16'h0250, 3, 6);
      display_conc <= 16'h4A00;
      wt(0);
      ck(concentration_out, 16'h4A00);
      ck(node_status_out, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         {alarm2_on, alarm1_on} <= 2'(i + 1);
         {fault_system, fault_pyro, fault_flow, fault_sensor} <= 4'(1 << i);
         wt(1);
         ck(alarm_switch_out, {av[(i+1)%4], 8'(i < 3)});
         ck(fault_switch_out, {fv[i], SW_ON});
      end
      ck(gas_label_out, 128'h6D7070203248);
      apb(1, ADDR_MEAS_MIN, 2);
      display_conc <= 16'h4B00;
      wt(0);
      @(posedge pclk);
      display_conc <= 16'h4C00;
      wt(0);
      ck(nw > 10, 1);
      apb(1, ADDR_MEAS_MIN, 0);
      apb(1, ADDR_MEAS_MAX, 1);
      wt(0);
      @(posedge pclk);
      wt(0);
      ck(nw >= 17 && nw <= 21, 1);
      apb(1, ADDR_MEAS_MAX, 0);
      repeat (3) @(posedge pclk);
      c = nm;
      repeat (100) @(posedge pclk);
      ck(nm, c);
      apb(1, ADDR_HB_INT, 1);
      wt(2);
      hv = heartbeat_out;
      @(posedge pclk);
      wt(2);
      ck(heartbeat_out, {8'h00, hv[7:0] + 8'h01});
      apb(1, ADDR_HB_INT, 0);
      repeat (3) @(posedge pclk);
      c = nh;
      repeat (100) @(posedge pclk);
      ck(nh, c);
      display_conc <= 16'h4D00;
      wt(0);
      repeat (3) @(posedge pclk);
      ck(irq, 0);
      apb(1, ADDR_IRQ_MASK, 1 << IRQ_MEAS);
      repeat (3) @(posedge pclk);
      ck(irq, 1);
      apb(0, ADDR_IRQ_STAT, 0);
      ck(rd[IRQ_MEAS], 1);
      repeat (3) @(posedge pclk);
      ck(irq, 0);
      net.clr(16'h0000);
      net.clr(16'h0003);
      repeat (2) @(posedge pclk);
      ck(nl, 1);
      apb(1, ADDR_CTRL, 1);
      repeat (3) @(posedge pclk);
      ck(user_mode, 1);
      mode_key_n <= 1'b0;
      repeat (20) @(posedge pclk);
      mode_key_n <= 1'b1;
      repeat (4) @(posedge pclk);
      ck(user_mode, 0);
      apb(1, ADDR_CTRL, 1);
      repeat (4) @(posedge pclk);
      ck(nid, 1);
      wrap_up();
   end
endmodule : test_network_variable_publisher
bind nvp_top nvp_assertions chk (.pclk, .presetn, .psel, .penable, .pready, .display_conc,
   .meas_send, .concentration_out, .node_status_out, .ind_send, .alarm_switch_out,
   .fault_switch_out, .heartbeat_out, .latch_clear_in, .latch_clear_valid,
   .latch_clear_pulse, .command_in, .command_valid, .command_reply_out, .reply_send,
   .node_id_reissue);
